/* File: rtl/bus_agent_pkg.sv */
package bus_agent_pkg;

    // ==========================================================
    // arbitration
    localparam int          SYM_AGENTS      = 4;
    localparam logic [1:0]  RESET_LAST_OWNER = 2'h3;

    // ==========================================================
    // reset timing
    localparam int          OUT_OFF_CLOCKS  = 2;
    localparam int          STRAP_DELAY     = 2;

    // ==========================================================
    // special transaction byte enables
    localparam logic [7:0]  BE_FLUSH_ACK    = 8'h05;
    localparam logic [7:0]  BE_STOP_ACK     = 8'h06;

    // ==========================================================
    // transaction length in clocks, request through response
    localparam int          XACT_CLOCKS     = 4;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_RUN,
        ST_FLUSH,
        ST_FLUSH_ACK,
        ST_STOP_ACK,
        ST_STOP_GRANT,
        ST_BUILT_IN_SELF_TEST
    } exec_state_t;

    // round-robin pick: first requester after last owner
    function automatic logic [2:0] rr_pick(input logic [3:0] req, input logic [1:0] last);
        logic [2:0] win;
        logic [1:0] idx;
        win = 3'h4;
        for (int i = 4; i >= 1; i--) begin
            idx = 2'(last + 2'(i));
            if (req[idx]) begin
                win = {1'b0, idx};
            end
        end
        return win;
    endfunction

endpackage

/* File: rtl/bus_arb_if.sv */
`timescale 1ns/1ps
interface bus_arb_if (
    input wire logic clock,
    input wire logic reset
);
    logic [3:0] symmetric_bus_req_n;
    logic       priority_bus_req_n;
    logic       block_next_req_n;
    logic       lock_n;
    logic       strobe_n;
    logic [7:0] byte_en;
    logic       special;

    modport agent (
        input  clock, reset, priority_bus_req_n, block_next_req_n,
        output symmetric_bus_req_n, lock_n, strobe_n, byte_en, special
    );
    modport prio (
        input  clock, reset, symmetric_bus_req_n, lock_n, strobe_n,
        output priority_bus_req_n, block_next_req_n
    );
endinterface

/* File: rtl/priority_bus_agent.sv */
`timescale 1ns/1ps
module priority_bus_agent (
    // bus
    bus_arb_if.prio   bus,
    // user side
    input  wire logic request,
    input  wire logic block_next,
    // status
    output logic      granted
);
    // ==========================================================
    // request line follows request directly; only the grant waits out any locked sequence
    logic prio_n;
    logic bnr_n;
    always_ff @(posedge bus.clock or posedge bus.reset) begin
        if (bus.reset) begin                        // [RULE2]
            prio_n  <= 1'b1;
            bnr_n   <= 1'b1;
            granted <= 1'b0;
        end else begin
            prio_n  <= !request;                    // [RULE16]
            bnr_n   <= !block_next;                 // [RULE17]
            granted <= !prio_n && bus.lock_n;       // [RULE18]
        end
    end
    assign bus.priority_bus_req_n = prio_n;
    assign bus.block_next_req_n   = bnr_n;

endmodule // priority_bus_agent

/* File: rtl/symmetric_bus_agent.sv */
// Operation
// RULE1: drive and sample on rising clock only
// RULE2: outputs released within two clocks of reset
// RULE3: cold reset clears state, caches, no writeback
// RULE4: straps sampled two clocks after reset release
// RULE5: warm init keeps caches, restarts at vector
// RULE6: init at reset release starts self test
// RULE7: flush writes back, invalidates, then acknowledges
// RULE8: flush at reset release tristates all outputs (here only the request lines are held inactive and no new transaction starts)
// RULE9: stop clock enters grant, acknowledges, keeps snooping
// RULE10: stop removal restarts clocks; bus clock untouched
// RULE11: interrupts disabled: inputs mean MASKABLE_IRQ, NMI
// RULE12: four symmetric plus one priority contender
// RULE13: transaction only while owning the bus
// RULE14: round robin, agent 0 first after reset
// RULE15: all agents compute same next owner
// RULE16: priority request holds off unlocked symmetric
// RULE17: block-next-request stalls new transactions
// RULE18: lock held whole sequence, no interruption
// RULE19: acknowledge codes 05 flush, 06 stop
// RULE20: winner's successor ranks highest next
// RULE21: request held until transaction issued
`timescale 1ns/1ps
module symmetric_bus_agent #(
    parameter logic [1:0] AGENT_ID   = 2'h0,
    parameter int         FLUSH_CLKS = 8
) (
    // bus
    bus_arb_if.agent         bus,
    // user side
    input  wire logic        init_n,
    input  wire logic        flush_n,
    input  wire logic        stop_clock_req_n,
    input  wire logic [1:0]  local_irq_in,
    input  wire logic        irq_ctrl_enable,
    input  wire logic        xact_req,
    input  wire logic        lock_req,
    // status
    output logic             xact_done,
    output logic             maskable_irq,
    output logic             nonmaskable_irq,
    output logic             built_in_self_test,
    output logic             outputs_tristated,
    output logic             core_clock_enable,
    output logic             caches_valid,
    output logic [1:0]       bus_owner,
    output logic             prio_owner
);
    // shared between execution control and arbitration
    bus_agent_pkg::exec_state_t state;
    logic                       ack_issue;
    logic                       owns_ok;

    // ==========================================================
    // reset tracking and strap capture
    logic [1:0] rst_cnt;
    logic       strapped;
    always_ff @(posedge bus.clock or posedge bus.reset) begin
        if (bus.reset) begin
            rst_cnt  <= 2'h0;
            strapped <= 1'b0;
            built_in_self_test <= 1'b0;
            outputs_tristated  <= 1'b0;
        end else begin
            // first edge after reset release only sees it inactive; straps on the next
            if (rst_cnt != 2'(bus_agent_pkg::STRAP_DELAY - 1)) begin
                rst_cnt <= rst_cnt + 2'h1;
            end else if (!strapped) begin                       // [RULE4]
                strapped <= 1'b1;
                built_in_self_test <= !init_n;                  // [RULE6]
                outputs_tristated  <= !flush_n;                 // [RULE8]
            end else if (state != bus_agent_pkg::ST_RESET) begin
                // a held init strap may skip the self-test state, so clear on any exit
                built_in_self_test <= 1'b0;
            end
        end
    end

    // ==========================================================
    // execution control
    logic [7:0] flush_cnt;
    logic       stop_seen;
    logic       ack_pending;
    logic [7:0] ack_code;
    always_ff @(posedge bus.clock or posedge bus.reset) begin
        if (bus.reset) begin
            state             <= bus_agent_pkg::ST_RESET;
            flush_cnt         <= 8'h00;
            caches_valid      <= 1'b0;                          // [RULE3]
            core_clock_enable <= 1'b1;
            stop_seen         <= 1'b0;
            ack_pending       <= 1'b0;
            ack_code          <= 8'h00;
        end else if (!init_n && strapped) begin
            state <= bus_agent_pkg::ST_RUN;                     // [RULE5]
            ack_pending <= 1'b0;
        end else begin
            case (state)
                bus_agent_pkg::ST_RESET: begin
                    if (strapped) begin
                        state <= built_in_self_test ? bus_agent_pkg::ST_BUILT_IN_SELF_TEST
                                                    : bus_agent_pkg::ST_RUN;
                    end
                end
                bus_agent_pkg::ST_BUILT_IN_SELF_TEST: begin
                    state <= bus_agent_pkg::ST_RUN;
                end
                bus_agent_pkg::ST_RUN: begin
                    caches_valid <= 1'b1;
                    if (!flush_n) begin
                        state     <= bus_agent_pkg::ST_FLUSH;   // [RULE7]
                        flush_cnt <= 8'(FLUSH_CLKS);
                    end else if (!stop_clock_req_n && !stop_seen) begin
                        stop_seen   <= 1'b1;
                        ack_pending <= 1'b1;
                        ack_code    <= bus_agent_pkg::BE_STOP_ACK;  // [RULE19]
                        state       <= bus_agent_pkg::ST_STOP_ACK;  // [RULE9]
                    end else if (stop_clock_req_n) begin
                        stop_seen <= 1'b0;
                    end
                end
                bus_agent_pkg::ST_FLUSH: begin
                    if (flush_cnt == 8'h00) begin
                        caches_valid <= 1'b0;
                        ack_pending  <= 1'b1;
                        ack_code     <= bus_agent_pkg::BE_FLUSH_ACK;  // [RULE19]
                        state        <= bus_agent_pkg::ST_FLUSH_ACK;
                    end else begin
                        flush_cnt <= flush_cnt - 8'h01;
                    end
                end
                bus_agent_pkg::ST_FLUSH_ACK: begin
                    if (ack_issue) begin
                        ack_pending <= 1'b0;
                    end else if (!ack_pending && flush_n) begin
                        state <= bus_agent_pkg::ST_RUN;
                    end
                end
                bus_agent_pkg::ST_STOP_ACK: begin
                    if (ack_issue) begin
                        ack_pending       <= 1'b0;
                        core_clock_enable <= 1'b0;  // snoop and bus stay live
                        state             <= bus_agent_pkg::ST_STOP_GRANT;
                    end
                end
                bus_agent_pkg::ST_STOP_GRANT: begin
                    if (stop_clock_req_n) begin
                        core_clock_enable <= 1'b1;              // [RULE10]
                        stop_seen         <= 1'b0;
                        state             <= bus_agent_pkg::ST_RUN;
                    end
                end
                default: state <= bus_agent_pkg::ST_RESET;
            endcase
        end
    end

    // ==========================================================
    // local interrupts, direct meaning only with controller off
    always_ff @(posedge bus.clock or posedge bus.reset) begin
        if (bus.reset) begin
            maskable_irq    <= 1'b0;
            nonmaskable_irq <= 1'b0;
        end else begin
            maskable_irq    <= !irq_ctrl_enable && local_irq_in[0];  // [RULE11]
            nonmaskable_irq <= !irq_ctrl_enable && local_irq_in[1];  // [RULE11]
        end
    end

    // ==========================================================
    // arbitration: every agent tracks the same owner
    logic [1:0] last_owner;
    logic [2:0] pick;
    logic       any_lock;
    logic       want;
    logic       active;
    logic [2:0] xcnt;
    logic       is_ack;
    assign pick      = bus_agent_pkg::rr_pick(~bus.symmetric_bus_req_n, last_owner);  // [RULE15]
    assign any_lock  = !bus.lock_n;
    assign want      = xact_req || ack_pending;
    assign ack_issue = !active && ack_pending && owns_ok;
    assign owns_ok = (pick == {1'b0, AGENT_ID}) && bus.priority_bus_req_n  // [RULE13] [RULE16]
                     && bus.block_next_req_n && strapped;           // [RULE17]

    always_ff @(posedge bus.clock or posedge bus.reset) begin
        if (bus.reset) begin
            last_owner <= bus_agent_pkg::RESET_LAST_OWNER;          // [RULE14]
            bus_owner  <= 2'h0;
            prio_owner <= 1'b0;
        end else if (!any_lock) begin                               // [RULE18]
            prio_owner <= !bus.priority_bus_req_n;              // [RULE12]
            if (bus.priority_bus_req_n && !pick[2] && bus.block_next_req_n) begin
                last_owner <= pick[1:0];                            // [RULE20]
                bus_owner  <= pick[1:0];
            end
        end
    end

    // own request line, strobe, lock, special code
    logic [3:0] req_drive_n;
    always_ff @(posedge bus.clock or posedge bus.reset) begin  // [RULE1]
        if (bus.reset) begin                                        // [RULE2]
            req_drive_n <= 4'hF;
            bus.strobe_n <= 1'b1;
            bus.lock_n   <= 1'b1;
            bus.byte_en  <= 8'h00;
            bus.special  <= 1'b0;
            active       <= 1'b0;
            xcnt         <= 3'h0;
            is_ack       <= 1'b0;
            xact_done    <= 1'b0;
        end else begin
            xact_done    <= 1'b0;
            bus.strobe_n <= 1'b1;
            if (outputs_tristated) begin                            // [RULE8]
                req_drive_n <= 4'hF;
            end else begin
                req_drive_n[AGENT_ID] <= !(want && !active);        // [RULE21]
            end
            if (active) begin
                if (xcnt == 3'(bus_agent_pkg::XACT_CLOCKS - 1)) begin
                    active      <= 1'b0;
                    xact_done   <= !is_ack;
                    bus.special <= 1'b0;
                    bus.byte_en <= 8'h00;
                    if (!lock_req || is_ack) begin
                        bus.lock_n <= 1'b1;                         // [RULE18]
                    end
                end else begin
                    xcnt <= xcnt + 3'h1;
                end
            end else if (want && !req_drive_n[AGENT_ID] && owns_ok
                         && !outputs_tristated && (!any_lock || !bus.lock_n)) begin
                active       <= 1'b1;                               // [RULE13]
                xcnt         <= 3'h0;
                is_ack       <= ack_pending;
                bus.strobe_n <= 1'b0;
                bus.special  <= ack_pending;
                bus.byte_en  <= ack_pending ? ack_code : 8'h00;     // [RULE19]
                bus.lock_n   <= !(lock_req && !ack_pending);
            end
        end
    end
    assign bus.symmetric_bus_req_n = req_drive_n;

endmodule // symmetric_bus_agent

/* File: test/bus_arb_checker.sv */
`timescale 1ns/1ps
module bus_arb_checker (
    // clock and reset
    input wire logic       clock,
    input wire logic       reset,
    // bus
    input wire logic [3:0] symmetric_bus_req_n,
    input wire logic       priority_bus_req_n,
    input wire logic       block_next_req_n,
    input wire logic       lock_n,
    input wire logic       strobe_n,
    input wire logic [7:0] byte_en,
    input wire logic       special
);
    logic issued;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // request may only drop once a strobe went out for it
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            issued <= 1'b0;
        end else if (!strobe_n) begin
            issued <= 1'b1;
        end else if (symmetric_bus_req_n[0]) begin
            issued <= 1'b0;
        end
    end

    // ====================================
    // transaction shape
    sequence s_held;
        ($stable(byte_en) && $stable(special))[*3];
    endsequence
    sequence s_locked;
        (!lock_n)[*3];
    endsequence

    property p_release;
        disable iff (1'b0) reset |-> ##[0:2] (strobe_n && lock_n && !special
            && &symmetric_bus_req_n && priority_bus_req_n && block_next_req_n);
    endproperty
    property p_owner;
        $fell(strobe_n) |-> !$past(symmetric_bus_req_n[0]);
    endproperty
    property p_prio;
        (!priority_bus_req_n && lock_n) |=> strobe_n;
    endproperty
    property p_block;
        !block_next_req_n |=> strobe_n;
    endproperty
    property p_codes;
        special |-> (byte_en == bus_agent_pkg::BE_FLUSH_ACK || byte_en == bus_agent_pkg::BE_STOP_ACK);
    endproperty
    property p_held;
        $fell(strobe_n) |=> s_held;
    endproperty
    property p_lock;
        ($fell(strobe_n) && !lock_n) |=> s_locked;
    endproperty
    property p_req_kept;
        $rose(symmetric_bus_req_n[0]) |-> (issued || !strobe_n);
    endproperty

    a_release: assert property (p_release) else $error("outputs not released");
    a_owner: assert property (p_owner) else $error("strobe without request");
    a_prio: assert property (p_prio) else $error("strobe under priority");
    a_block: assert property (p_block) else $error("strobe while blocked");
    a_codes: assert property (p_codes) else $error("bad special code");
    a_held: assert property (p_held) else $error("request fields moved");
    a_lock: assert property (p_lock) else $error("lock dropped early");
    a_req_kept: assert property (p_req_kept) else $error("request dropped");
endmodule // bus_arb_checker

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic       clock = 1'b0;
    logic       reset = 1'b1;
    logic       init_n, flush_n, stop_clock_req_n, irq_ctrl_enable, xact_req, lock_req;
    logic       request, block_next, xact_done, maskable_irq, nonmaskable_irq;
    logic       built_in_self_test, outputs_tristated, core_clock_enable, caches_valid;
    logic       prio_owner, granted, got, seen_built_in_self_test, seen_tri;
    logic [1:0] local_irq_in, bus_owner;
    logic [7:0] lfsr;
    int         err_count, checked, n;

    always #12.5 clock = ~clock;

    bus_arb_if u_bus_arb_if (.clock(clock), .reset(reset));
    symmetric_bus_agent u_symmetric_bus_agent (.bus(u_bus_arb_if), .init_n(init_n),
        .flush_n(flush_n), .stop_clock_req_n(stop_clock_req_n), .local_irq_in(local_irq_in),
        .irq_ctrl_enable(irq_ctrl_enable), .xact_req(xact_req), .lock_req(lock_req),
        .xact_done(xact_done), .maskable_irq(maskable_irq), .nonmaskable_irq(nonmaskable_irq),
        .built_in_self_test(built_in_self_test), .outputs_tristated(outputs_tristated),
        .core_clock_enable(core_clock_enable), .caches_valid(caches_valid),
        .bus_owner(bus_owner), .prio_owner(prio_owner));
    priority_bus_agent u_priority_bus_agent (.bus(u_bus_arb_if), .request(request),
        .block_next(block_next), .granted(granted));
    bus_arb_checker u_bus_arb_checker (.clock(clock), .reset(reset),
        .symmetric_bus_req_n(u_bus_arb_if.symmetric_bus_req_n),
        .priority_bus_req_n(u_bus_arb_if.priority_bus_req_n),
        .block_next_req_n(u_bus_arb_if.block_next_req_n), .lock_n(u_bus_arb_if.lock_n),
        .strobe_n(u_bus_arb_if.strobe_n), .byte_en(u_bus_arb_if.byte_en),
        .special(u_bus_arb_if.special));

    // ====================================
    // helpers
    function automatic logic [7:0] next_rand(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task conclude;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // straps watched from release on, since the self-test flag may only pulse
    task do_reset(input logic i_n, input logic f_n);
        @(negedge clock);
        reset = 1'b1;
        init_n = i_n;
        flush_n = f_n;
        repeat (6) @(negedge clock);
        check("caches", {7'h0, caches_valid}, 8'h00);
        reset = 1'b0;
        seen_built_in_self_test = 1'b0;
        seen_tri = 1'b0;
        repeat (8) begin
            @(posedge clock);
            seen_built_in_self_test = seen_built_in_self_test | (built_in_self_test === 1'b1);
            seen_tri = seen_tri | (outputs_tristated === 1'b1);
        end
        @(negedge clock);
        init_n = 1'b1;
        flush_n = 1'b1;
    endtask

    // done looked at mid-cycle, so the request drops before the next edge re-arms it
    task wait_done(input int lim);
        got = 1'b0;
        for (n = 0; n < lim && !got; n++) begin
            @(negedge clock);
            got = (xact_done === 1'b1);
        end
    endtask

    task run_xact(input logic lk);
        xact_req = 1'b1;
        lock_req = lk;
        wait_done(40);
        xact_req = 1'b0;
        lock_req = 1'b0;
        check("done", {7'h0, got}, 8'h01);
    endtask

    task stall(input logic use_prio);
        request = use_prio;
        block_next = !use_prio;
        repeat (2) @(negedge clock);
        xact_req = 1'b1;
        wait_done(12);
        check("stalled", {7'h0, got}, 8'h00);
        if (use_prio) check("granted", {6'h0, granted, prio_owner}, 8'h03);
        request = 1'b0;
        block_next = 1'b0;
        wait_done(40);
        xact_req = 1'b0;
        check("resumed", {7'h0, got}, 8'h01);
    endtask

    // an earlier acknowledge may still be on the bus: wait for it to end first
    task wait_special(input logic [7:0] code);
        for (n = 0; n < 80 && u_bus_arb_if.special !== 1'b0; n++) @(negedge clock);
        for (n = 0; n < 80 && u_bus_arb_if.special !== 1'b1; n++) @(negedge clock);
        check("special", u_bus_arb_if.byte_en, code);
        @(negedge clock);
    endtask

    // ====================================
    // main sequence
    initial begin
        {init_n, flush_n, stop_clock_req_n} = 3'h7;
        {irq_ctrl_enable, xact_req, lock_req, request, block_next} = 5'h00;
        local_irq_in = 2'h0;
        lfsr = 8'h5C;
        err_count = 0;
        checked = 0;
        do_reset(1'b0, 1'b1);
        check("self test", {7'h0, seen_built_in_self_test}, 8'h01);
        do_reset(1'b1, 1'b0);
        check("tristate", {7'h0, seen_tri}, 8'h01);
        do_reset(1'b1, 1'b1);
        check("plain straps", {6'h0, seen_built_in_self_test, seen_tri}, 8'h00);
        run_xact(1'b0);
        check("owner", {6'h0, bus_owner}, 8'h00);
        stall(1'b1);
        stall(1'b0);
        flush_n = 1'b0;
        wait_special(bus_agent_pkg::BE_FLUSH_ACK);
        check("flushed", {7'h0, caches_valid}, 8'h00);
        flush_n = 1'b1;
        stop_clock_req_n = 1'b0;
        wait_special(bus_agent_pkg::BE_STOP_ACK);
        repeat (4) @(negedge clock);
        check("core gated", {7'h0, core_clock_enable}, 8'h00);
        stop_clock_req_n = 1'b1;
        repeat (4) @(negedge clock);
        check("core running", {7'h0, core_clock_enable}, 8'h01);
        repeat (12) begin
            lfsr = next_rand(lfsr);
            local_irq_in = lfsr[1:0];
            irq_ctrl_enable = lfsr[3];
            repeat (3) @(negedge clock);
            check("irq", {6'h0, nonmaskable_irq, maskable_irq},
                  {6'h0, lfsr[1:0] & {2{!lfsr[3]}}});
            run_xact(lfsr[2]);
            check("owner", {6'h0, bus_owner}, 8'h00);
        end
        conclude();
    end

    initial begin
        #150000;
        err_count++;
        conclude();
    end
endmodule // testbench
